// >>> core/tvl_limits.sv
// Purpose: Temperature and input voltage limits, status and retry control.
// Assumes: Commands arrive decoded from the serial interface, one per cycle.
// Notes:   Strap values are captured on the first edge after reset release.
`timescale 1ns/10ps
`include "tvl_params.svh"
module tvl_limits
  import tvl_pkg::*;
#(
  parameter int unsigned RETRY_STEP_CYC = `TVL_RETRY_STEP_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire tvl_cmd_t    cmd,
  input  wire tvl_meas_t   meas,
  input  wire logic [15:0] undertemp_warning_threshold,
  input  wire logic [15:0] uv_strap_threshold,
  input  wire logic        on_request,
  output logic             rd_valid,
  output logic [15:0]      rd_data,
  output logic             power_enable,
  output logic             alert_n
);

  // Configuration registers.
  logic [15:0] undertemp_fault_threshold;
  logic [5:0]  undertemp_fault_action;
  logic [15:0] input_overvolt_fault_threshold;
  logic [5:0]  input_overvolt_fault_action;
  logic [15:0] input_overvolt_warn_threshold;
  logic [15:0] input_undervolt_warn_threshold;
  logic [15:0] input_undervolt_fault_threshold;
  logic [5:0]  input_undervolt_fault_action;
  logic        strap_done;

  logic [15:0] next_ut_lim;
  logic [5:0]  next_ut_act;
  logic [15:0] next_ov_lim;
  logic [5:0]  next_ov_act;
  logic [15:0] next_ov_warn;
  logic [15:0] next_uv_warn;
  logic [15:0] next_uv_lim;
  logic [5:0]  next_uv_act;
  logic        next_strap_done;

  // Fault levels and sticky status.
  logic        ut_fault;
  logic        ov_fault;
  logic        uv_fault;
  logic        input_overvolt_warn_flag;
  logic        input_undervolt_warn_flag;
  logic        input_undervolt_fault_event;
  logic        st_ov_fault;
  logic        st_ut_fault;
  logic        st_input;
  logic        unlisted_fault_flag;
  logic        next_ut_fault;
  logic        next_ov_fault;
  logic        next_uv_fault;
  logic        next_ov_warn_flag;
  logic        next_uv_warn_flag;
  logic        next_uv_event;
  logic        next_st_ov_fault;
  logic        next_st_ut_fault;
  logic        next_st_input;
  logic        next_unlisted;

  // Readback and output control.
  logic        next_rd_valid;
  logic [15:0] next_rd_data;
  logic        next_power_enable;
  logic        next_alert_n;

  // Helper terms.
  logic        wr;
  logic        rd;
  logic        clr;
  logic signed [47:0] t_val;
  logic signed [47:0] v_val;
  logic        ut_below;
  logic        ut_above_warn;
  logic        ov_above;
  logic        ov_warn_above;
  logic        uv_below;
  logic        uv_warn_below;
  logic        uv_above_warn;
  logic [15:0] strap_warn;
  logic signed [15:0] scaled;
  logic [15:0] status_word;
  logic [7:0]  status_input;
  logic [7:0]  status_temp;
  logic [2:0]  shut;
  logic [2:0]  hold;
  logic [2:0]  stop;

  assign wr  = cmd.valid && cmd.write;
  assign rd  = cmd.valid && !cmd.write;
  assign clr = wr && cmd.code == `TVL_CMD_CLEAR_STATUS;

  // Comparators run on the shared fixed-point scale of the decoder.
  always_comb begin
    t_val         = tvl_l11_val(meas.temp);
    v_val         = tvl_l11_val(meas.vin);
    ut_below      = t_val < tvl_l11_val(undertemp_fault_threshold);
    ut_above_warn = t_val > tvl_l11_val(undertemp_warning_threshold);
    ov_above      = v_val > tvl_l11_val(input_overvolt_fault_threshold);
    ov_warn_above = v_val > tvl_l11_val(input_overvolt_warn_threshold);
    uv_below      = v_val < tvl_l11_val(input_undervolt_fault_threshold);
    uv_warn_below = v_val < tvl_l11_val(input_undervolt_warn_threshold);
    uv_above_warn = v_val > tvl_l11_val(input_undervolt_warn_threshold);
  end

  // Warning default is the strap mantissa times eleven over ten; the
  // exponent is raised by one when the mantissa would leave its range,
  // which costs one bit of precision.
  always_comb begin
    scaled = (16'(signed'(uv_strap_threshold[10:0])) * `TVL_UV_WARN_NUM)
             / `TVL_UV_WARN_DEN;
    strap_warn = {uv_strap_threshold[15:11], scaled[10:0]};
    if (scaled > `TVL_L11_MANT_MAX || scaled < `TVL_L11_MANT_MIN) begin
      strap_warn = {uv_strap_threshold[15:11] + 5'h01, scaled[11:1]};
    end
  end

  // Register writes and the strap capture.
  always_comb begin
    next_ut_lim     = undertemp_fault_threshold;
    next_ut_act     = undertemp_fault_action;
    next_ov_lim     = input_overvolt_fault_threshold;
    next_ov_act     = input_overvolt_fault_action;
    next_ov_warn    = input_overvolt_warn_threshold;
    next_uv_warn    = input_undervolt_warn_threshold;
    next_uv_lim     = input_undervolt_fault_threshold;
    next_uv_act     = input_undervolt_fault_action;
    next_strap_done = 1'b1;
    if (!strap_done) begin
      next_uv_lim  = uv_strap_threshold;
      next_uv_warn = strap_warn;
    end else if (wr) begin
      case (cmd.code)
        `TVL_CMD_UT_FAULT_LIM: next_ut_lim  = cmd.wdata;
        `TVL_CMD_UT_FAULT_ACT: next_ut_act  = cmd.wdata[5:0];
        `TVL_CMD_OV_FAULT_LIM: next_ov_lim  = cmd.wdata;
        `TVL_CMD_OV_FAULT_ACT: next_ov_act  = cmd.wdata[5:0];
        `TVL_CMD_OV_WARN_LIM:  next_ov_warn = cmd.wdata;
        `TVL_CMD_UV_WARN_LIM:  next_uv_warn = cmd.wdata;
        `TVL_CMD_UV_FAULT_LIM: next_uv_lim  = cmd.wdata;
        `TVL_CMD_UV_FAULT_ACT: next_uv_act  = cmd.wdata[5:0];
        default: begin
          next_ut_lim = undertemp_fault_threshold;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      undertemp_fault_threshold       <= `TVL_RST_UT_FAULT_LIM;
      undertemp_fault_action          <= 6'(`TVL_RST_ACTION);
      input_overvolt_fault_threshold  <= `TVL_RST_OV_FAULT_LIM;
      input_overvolt_fault_action     <= 6'(`TVL_RST_ACTION);
      input_overvolt_warn_threshold   <= `TVL_RST_OV_WARN_LIM;
      input_undervolt_warn_threshold  <= 16'h0000;
      input_undervolt_fault_threshold <= 16'h0000;
      input_undervolt_fault_action    <= 6'(`TVL_RST_ACTION);
      strap_done                      <= 1'b0;
    end else begin
      undertemp_fault_threshold       <= next_ut_lim;
      undertemp_fault_action          <= next_ut_act;
      input_overvolt_fault_threshold  <= next_ov_lim;
      input_overvolt_fault_action     <= next_ov_act;
      input_overvolt_warn_threshold   <= next_ov_warn;
      input_undervolt_warn_threshold  <= next_uv_warn;
      input_undervolt_fault_threshold <= next_uv_lim;
      input_undervolt_fault_action    <= next_uv_act;
      strap_done                      <= next_strap_done;
    end
  end

  // Fault levels move only on a measurement; sticky bits let a set win
  // over a clear arriving in the same cycle.
  always_comb begin
    next_ut_fault     = ut_fault;
    next_ov_fault     = ov_fault;
    next_uv_fault     = uv_fault;
    next_ov_warn_flag = input_overvolt_warn_flag & ~clr;
    next_uv_warn_flag = input_undervolt_warn_flag & ~clr;
    next_uv_event     = input_undervolt_fault_event & ~clr;
    next_st_ov_fault  = st_ov_fault & ~clr;
    next_st_ut_fault  = st_ut_fault & ~clr;
    next_st_input     = st_input & ~clr;
    next_unlisted     = unlisted_fault_flag & ~clr;
    if (meas.valid) begin
      next_ut_fault = ut_fault ? !ut_above_warn : ut_below;
      next_ov_fault = ov_above;
      next_uv_fault = uv_fault ? !uv_above_warn : uv_below;
      if (next_ut_fault) begin
        next_st_ut_fault = 1'b1;
      end
      if (next_ov_fault) begin
        next_st_ov_fault = 1'b1;
        next_st_input    = 1'b1;
      end
      if (next_uv_fault) begin
        next_uv_event = 1'b1;
        next_st_input = 1'b1;
      end
      if (ov_warn_above) begin
        next_ov_warn_flag = 1'b1;
        next_st_input     = 1'b1;
        next_unlisted     = 1'b1;
      end
      if (uv_warn_below) begin
        next_uv_warn_flag = 1'b1;
        next_st_input     = 1'b1;
        next_unlisted     = 1'b1;
      end
    end
    next_alert_n = !(next_ov_warn_flag | next_uv_warn_flag | next_uv_event |
                     next_st_ov_fault | next_st_ut_fault);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ut_fault                    <= 1'b0;
      ov_fault                    <= 1'b0;
      uv_fault                    <= 1'b0;
      input_overvolt_warn_flag    <= 1'b0;
      input_undervolt_warn_flag   <= 1'b0;
      input_undervolt_fault_event <= 1'b0;
      st_ov_fault                 <= 1'b0;
      st_ut_fault                 <= 1'b0;
      st_input                    <= 1'b0;
      unlisted_fault_flag         <= 1'b0;
      alert_n                     <= 1'b1;
    end else begin
      ut_fault                    <= next_ut_fault;
      ov_fault                    <= next_ov_fault;
      uv_fault                    <= next_uv_fault;
      input_overvolt_warn_flag    <= next_ov_warn_flag;
      input_undervolt_warn_flag   <= next_uv_warn_flag;
      input_undervolt_fault_event <= next_uv_event;
      st_ov_fault                 <= next_st_ov_fault;
      st_ut_fault                 <= next_st_ut_fault;
      st_input                    <= next_st_input;
      unlisted_fault_flag         <= next_unlisted;
      alert_n                     <= next_alert_n;
    end
  end

  // One retry unit per fault; a held shutdown elsewhere stops retrying.
  assign stop[0] = !on_request || hold[1] || hold[2];
  assign stop[1] = !on_request || hold[0] || hold[2];
  assign stop[2] = !on_request || hold[0] || hold[1];

  tvl_retry_unit #(.STEP_CYC(RETRY_STEP_CYC)) u_ut_retry (
    .clk_sys      (clk_sys),
    .rstn         (rstn),
    .fault_active (ut_fault),
    .stop         (stop[0]),
    .action       ({`TVL_ACT_RSV_PATTERN, undertemp_fault_action}),
    .shut_off     (shut[0]),
    .hold         (hold[0])
  );

  tvl_retry_unit #(.STEP_CYC(RETRY_STEP_CYC)) u_ov_retry (
    .clk_sys      (clk_sys),
    .rstn         (rstn),
    .fault_active (ov_fault),
    .stop         (stop[1]),
    .action       ({`TVL_ACT_RSV_PATTERN, input_overvolt_fault_action}),
    .shut_off     (shut[1]),
    .hold         (hold[1])
  );

  tvl_retry_unit #(.STEP_CYC(RETRY_STEP_CYC)) u_uv_retry (
    .clk_sys      (clk_sys),
    .rstn         (rstn),
    .fault_active (uv_fault),
    .stop         (stop[2]),
    .action       ({`TVL_ACT_RSV_PATTERN, input_undervolt_fault_action}),
    .shut_off     (shut[2]),
    .hold         (hold[2])
  );

  // Status views and readback; unknown codes read as zero.
  always_comb begin
    status_word = 16'h0000;
    status_word[`TVL_SW_INPUT]       = st_input;
    status_word[`TVL_SW_UV_FAULT]    = input_undervolt_fault_event;
    status_word[`TVL_SW_TEMPERATURE] = st_ut_fault;
    status_word[`TVL_SW_UNLISTED]    = unlisted_fault_flag;
    status_input = 8'h00;
    status_input[`TVL_SI_OV_FAULT] = st_ov_fault;
    status_input[`TVL_SI_OV_WARN]  = input_overvolt_warn_flag;
    status_input[`TVL_SI_UV_WARN]  = input_undervolt_warn_flag;
    status_input[`TVL_SI_UV_FAULT] = input_undervolt_fault_event;
    status_temp = 8'h00;
    status_temp[`TVL_ST_UT_FAULT] = st_ut_fault;
    next_rd_valid = rd;
    next_rd_data  = 16'h0000;
    if (rd) begin
      case (cmd.code)
        `TVL_CMD_UT_FAULT_LIM: next_rd_data = undertemp_fault_threshold;
        `TVL_CMD_UT_FAULT_ACT:
          next_rd_data = {8'h00, `TVL_ACT_RSV_PATTERN,
                          undertemp_fault_action};
        `TVL_CMD_OV_FAULT_LIM: next_rd_data = input_overvolt_fault_threshold;
        `TVL_CMD_OV_FAULT_ACT:
          next_rd_data = {8'h00, `TVL_ACT_RSV_PATTERN,
                          input_overvolt_fault_action};
        `TVL_CMD_OV_WARN_LIM:  next_rd_data = input_overvolt_warn_threshold;
        `TVL_CMD_UV_WARN_LIM:  next_rd_data = input_undervolt_warn_threshold;
        `TVL_CMD_UV_FAULT_LIM: next_rd_data = input_undervolt_fault_threshold;
        `TVL_CMD_UV_FAULT_ACT:
          next_rd_data = {8'h00, `TVL_ACT_RSV_PATTERN,
                          input_undervolt_fault_action};
        `TVL_CMD_STATUS_WORD:  next_rd_data = status_word;
        `TVL_CMD_STATUS_INPUT: next_rd_data = {8'h00, status_input};
        `TVL_CMD_STATUS_TEMP:  next_rd_data = {8'h00, status_temp};
        default:               next_rd_data = 16'h0000;
      endcase
    end
    next_power_enable = on_request && !(|shut);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_valid     <= 1'b0;
      rd_data      <= 16'h0000;
      power_enable <= 1'b0;
    end else begin
      rd_valid     <= next_rd_valid;
      rd_data      <= next_rd_data;
      power_enable <= next_power_enable;
    end
  end

  sequence s_ut_cross;
    meas.valid && !ut_fault && ut_below;
  endsequence

  a_ut_fault_set: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_ut_cross |=> ut_fault ##2 !power_enable)
    else $error("Under-temperature crossing did not shut the output.");

  a_ut_hysteresis: assert property (@(posedge clk_sys) disable iff (!rstn)
    ut_fault && meas.valid && !ut_above_warn |=> ut_fault)
    else $error("Under-temperature fault released below warning level.");

  a_ov_fault_set: assert property (@(posedge clk_sys) disable iff (!rstn)
    meas.valid && ov_above |=> ov_fault && st_ov_fault && !alert_n)
    else $error("Overvoltage crossing was not flagged.");

  a_ov_warn_flags: assert property (@(posedge clk_sys) disable iff (!rstn)
    meas.valid && ov_warn_above |=> input_overvolt_warn_flag && st_input
      && unlisted_fault_flag && !alert_n)
    else $error("Overvoltage warning did not set its status bits.");

  a_uv_warn_flags: assert property (@(posedge clk_sys) disable iff (!rstn)
    meas.valid && uv_warn_below |=> input_undervolt_warn_flag && st_input
      && unlisted_fault_flag && !alert_n)
    else $error("Undervoltage warning did not set its status bits.");

  a_uv_hysteresis: assert property (@(posedge clk_sys) disable iff (!rstn)
    uv_fault && meas.valid && !uv_above_warn |=> uv_fault)
    else $error("Undervoltage fault released below warning level.");

  a_strap_capture: assert property (@(posedge clk_sys) disable iff (!rstn)
    rstn && !strap_done |=>
      input_undervolt_fault_threshold == $past(uv_strap_threshold)
      && input_undervolt_warn_threshold == $past(strap_warn))
    else $error("Strap thresholds were not loaded after reset.");

  a_action_pattern: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd && cmd.code == `TVL_CMD_UV_FAULT_ACT |=> rd_valid
      && rd_data[7:6] == `TVL_ACT_RSV_PATTERN)
    else $error("Action byte readback lost its fixed pattern.");

  a_no_meas_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    !meas.valid |=> ut_fault == $past(ut_fault)
      && uv_fault == $past(uv_fault))
    else $error("Fault level moved without a measurement.");

endmodule // tvl_limits

// >>> core/tvl_params.svh
// Purpose: Command codes, field positions, reset values and timing counts.
// Assumes: 250 MHz system clock.
// Notes:   Definitions only; included by bare name.
`ifndef TVL_PARAMS_SVH
`define TVL_PARAMS_SVH

`define TVL_CMD_CLEAR_STATUS   8'h03
`define TVL_CMD_UT_FAULT_LIM   8'h53
`define TVL_CMD_UT_FAULT_ACT   8'h54
`define TVL_CMD_OV_FAULT_LIM   8'h55
`define TVL_CMD_OV_FAULT_ACT   8'h56
`define TVL_CMD_OV_WARN_LIM    8'h57
`define TVL_CMD_UV_WARN_LIM    8'h58
`define TVL_CMD_UV_FAULT_LIM   8'h59
`define TVL_CMD_UV_FAULT_ACT   8'h5A
`define TVL_CMD_STATUS_WORD    8'h79
`define TVL_CMD_STATUS_INPUT   8'h7C
`define TVL_CMD_STATUS_TEMP    8'h7D

`define TVL_RST_UT_FAULT_LIM   16'hE530
`define TVL_RST_OV_FAULT_LIM   16'hD3A0
`define TVL_RST_OV_WARN_LIM    16'hD34D
`define TVL_RST_ACTION         8'h80

`define TVL_ACT_RSV_PATTERN    2'h2
`define TVL_RETRY_NONE         3'h0
`define TVL_RETRY_ALWAYS       3'h7

`define TVL_SW_INPUT           13
`define TVL_SW_UV_FAULT        3
`define TVL_SW_TEMPERATURE     2
`define TVL_SW_UNLISTED        0
`define TVL_SI_OV_FAULT        7
`define TVL_SI_OV_WARN         6
`define TVL_SI_UV_WARN         5
`define TVL_SI_UV_FAULT        4
`define TVL_ST_UT_FAULT        4

`define TVL_L11_MANT_MAX       16'sh03FF
`define TVL_L11_MANT_MIN       -16'sh0400
`define TVL_UV_WARN_NUM        16'sh000B
`define TVL_UV_WARN_DEN        16'sh000A

`define TVL_CLK_MHZ            250
`define TVL_RETRY_STEP_MS      35
`define TVL_RETRY_STEP_CYC     (`TVL_RETRY_STEP_MS * `TVL_CLK_MHZ * 1000)

`endif

// >>> core/tvl_pkg.sv
// Purpose: Shared types for the fault limit and retry block.
// Assumes: Linear-eleven words: 5-bit signed exponent, 11-bit mantissa.
// Notes:   The decode helper scales by 2^16 so every exponent is exact.
package tvl_pkg;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } tvl_cmd_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] temp;
    logic [15:0] vin;
  } tvl_meas_t;

  typedef struct packed {
    logic [1:0] rsv;
    logic [2:0] mode;
    logic [2:0] delay;
  } tvl_action_t;

  typedef enum logic [2:0] {
    TVL_RUN  = 3'b001,
    TVL_HOLD = 3'b010,
    TVL_WAIT = 3'b100
  } tvl_retry_state_t;

  // Shift of exponent plus 16 is the exponent with its sign bit flipped.
  function automatic logic signed [47:0] tvl_l11_val(input logic [15:0] w);
    logic signed [47:0] m;
    logic [4:0]         sh;
    m = 48'(signed'(w[10:0]));
    sh = {~w[15], w[14:11]};
    return m <<< sh;
  endfunction

endpackage

// >>> core/tvl_retry_unit.sv
// Purpose: Shutdown and restart sequencing for one fault source.
// Assumes: fault_active is a level from the limit comparators.
// Notes:   Unused retry codes behave as no retry.
`timescale 1ns/10ps
`include "tvl_params.svh"
module tvl_retry_unit
  import tvl_pkg::*;
#(
  parameter int unsigned STEP_CYC = `TVL_RETRY_STEP_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        fault_active,
  input  wire logic        stop,
  input  wire tvl_action_t action,
  output logic             shut_off,
  output logic             hold
);

  tvl_retry_state_t state;
  tvl_retry_state_t next_state;
  logic [23:0]      cyc;
  logic [23:0]      next_cyc;
  logic [2:0]       step;
  logic [2:0]       next_step;
  logic             next_shut_off;
  logic             next_hold;
  logic             step_tick;

  assign step_tick = (cyc == 24'(STEP_CYC - 1));

  always_comb begin
    next_state = state;
    next_cyc   = 24'h000000;
    next_step  = step;
    case (state)
      TVL_RUN: begin
        if (fault_active) begin
          next_step = 3'h0;
          if (action.mode == `TVL_RETRY_ALWAYS && !stop) begin
            next_state = TVL_WAIT;
          end else begin
            next_state = TVL_HOLD;
          end
        end
      end
      TVL_HOLD: begin
        if (!fault_active) begin
          next_state = TVL_RUN;
        end
      end
      TVL_WAIT: begin
        // Commanded off or another unit's held shutdown ends the retry loop.
        if (stop) begin
          next_state = TVL_HOLD;
        end else if (step_tick) begin
          if (step == action.delay) begin
            next_state = TVL_RUN;
          end else begin
            next_step = step + 3'h1;
          end
        end else begin
          next_cyc = cyc + 24'h000001;
        end
      end
      default: begin
        next_state = TVL_HOLD;
      end
    endcase
    next_shut_off = (next_state != TVL_RUN);
    next_hold     = (next_state == TVL_HOLD);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state    <= TVL_RUN;
      cyc      <= 24'h000000;
      step     <= 3'h0;
      shut_off <= 1'b0;
      hold     <= 1'b0;
    end else begin
      state    <= next_state;
      cyc      <= next_cyc;
      step     <= next_step;
      shut_off <= next_shut_off;
      hold     <= next_hold;
    end
  end

  a_hold_until_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
    state == TVL_HOLD && fault_active |=> state == TVL_HOLD)
    else $error("Held shutdown released while the fault was active.");

  a_retry_step_len: assert property (@(posedge clk_sys) disable iff (!rstn)
    state == TVL_WAIT && !stop && !step_tick |=> step == $past(step))
    else $error("Retry step advanced before a full step elapsed.");

endmodule // tvl_retry_unit

// >>> tb/tvl_host.sv
// Purpose: Host model issuing decoded commands to the limit block.
// Assumes: One command per cycle; reads answer one cycle after.
// Notes:   Idle fields carry inverted data so stale values never linger.
`timescale 1ns/10ps
module tvl_host
  import tvl_pkg::*;
(
  input  wire logic clk_sys,
  output tvl_cmd_t  cmd
);
  initial cmd = '0;
  task automatic issue(input logic w, input logic [7:0] c,
                       input logic [15:0] d);
    @(posedge clk_sys);
    cmd <= '{1'b1, w, c, d};
    @(posedge clk_sys);
    cmd <= '{1'b0, 1'b0, ~c, ~d};
  endtask
endmodule // tvl_host

// >>> tb/tvl_limits_tb_top.sv
// Purpose: Self-checking bench for the fault limit and retry block.
// Assumes: Retry step shortened to four cycles.
// Notes:   Strap 8 V, so the warning release point is D233h.
`timescale 1ns/10ps
module tvl_limits_tb_top
  import tvl_pkg::*;
;
  localparam int unsigned STEP = 4;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        on_request = 1'b1;
  tvl_cmd_t    cmd;
  tvl_meas_t   meas = '0;
  logic        rd_valid;
  logic        power_enable;
  logic        alert_n;
  logic [15:0] rd_data;
  logic [15:0] pe_alert;
  int          n_errors = 0;
  int          n_compared = 0;
  tvl_host i_tvl_host (.clk_sys(clk_sys), .cmd(cmd));
  tvl_limits #(.RETRY_STEP_CYC(STEP)) i_tvl_limits (
    .clk_sys(clk_sys), .rstn(rstn), .cmd(cmd), .meas(meas),
    .undertemp_warning_threshold(16'hDC40),
    .uv_strap_threshold(16'hD200), .on_request(on_request),
    .rd_valid(rd_valid), .rd_data(rd_data),
    .power_enable(power_enable), .alert_n(alert_n));
  initial forever #2 clk_sys = ~clk_sys;
  assign pe_alert = {14'h0000, power_enable, alert_n};
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input string what, input logic [7:0] c,
                      input logic [15:0] exp);
    i_tvl_host.issue(1'b0, c, 16'h0000);
    #1;
    chk(what, exp, (rd_valid === 1'b1) ? rd_data : ~exp);
  endtask
  task automatic put(input logic [15:0] t, input logic [15:0] v);
    @(posedge clk_sys);
    meas <= '{1'b1, t, v};
    @(posedge clk_sys);
    meas <= '{1'b0, ~t, ~v};
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic clr();
    i_tvl_host.issue(1'b1, 8'h03, 16'h0000);
    @(posedge clk_sys);
    #1;
    chk("alert after clear", 16'h0001, {15'h0000, alert_n});
  endtask
  task automatic t_reset();
    logic [7:0]  c [8] = '{8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58,
                           8'h59, 8'h5A};
    logic [15:0] e [8] = '{16'hE530, 16'h0080, 16'hD3A0, 16'h0080,
                           16'hD34D, 16'hD233, 16'hD200, 16'h0080};
    foreach (c[i]) rchk("reset value", c[i], e[i]);
    i_tvl_host.issue(1'b1, 8'h54, 16'hFF07);
    rchk("action write", 8'h54, 16'h0087);
  endtask
  task automatic t_ut();
    put(16'h07CE, 16'h000C);
    chk("ut shutdown", 16'h0000, pe_alert);
    rchk("temp status", 8'h7D, 16'h0010);
    put(16'h07D8, 16'h000C);
    chk("ut hysteresis", 16'h0000, {15'h0000, power_enable});
    put(16'h0019, 16'h000C);
    chk("ut release", 16'h0001, {15'h0000, power_enable});
    clr();
  endtask
  task automatic t_input();
    put(16'h0019, 16'h000E);
    chk("ov warn", 16'h0002, pe_alert);
    rchk("input status", 8'h7C, 16'h0040);
    rchk("status word", 8'h79, 16'h2001);
    clr();
    put(16'h0019, 16'h0007);
    chk("uv fault", 16'h0000, pe_alert);
    rchk("input status", 8'h7C, 16'h0030);
    rchk("status word", 8'h79, 16'h2009);
    put(16'h0019, 16'hF811);
    chk("uv hysteresis", 16'h0000, {15'h0000, power_enable});
    put(16'h0019, 16'h000C);
    chk("uv release", 16'h0001, {15'h0000, power_enable});
    clr();
  endtask
  task automatic wait_pe(input logic lvl, output int n);
    n = 0;
    while (power_enable !== lvl && n < 100) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask
  task automatic t_retry();
    int n;
    i_tvl_host.issue(1'b1, 8'h56, 16'h0039);
    put(16'h0019, 16'h000F);
    wait_pe(1'b1, n);
    wait_pe(1'b0, n);
    wait_pe(1'b1, n);
    chk("retry span", 16'h0001, 16'(n >= 8 && n <= 10));
    @(posedge clk_sys);
    on_request <= 1'b0;
    repeat (4) @(posedge clk_sys);
    on_request <= 1'b1;
    #1;
    // A dropped request parks the loop, so no restart follows its return.
    wait_pe(1'b1, n);
    chk("retry stopped", 16'h0064, 16'(n));
  endtask
  task automatic conclude();
    $display("Compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_reset();
    t_ut();
    t_input();
    t_retry();
    conclude();
  end
  initial begin
    #20000;
    n_errors++;
    conclude();
  end
endmodule // tvl_limits_tb_top
